// ==== core/fpucw_core.sv ====
// fp control write, convert-to-double and convert-to-long execution block
`timescale 1ns/10ps
`default_nettype none
module fpucw_core (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire fpucw_pkg::fpucw_req_t req,
  input wire logic cuEnable,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output fpucw_pkg::fpucw_res_t res,
  output fpucw_pkg::fpucw_trap_t trap
);
  // -------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------
  logic rstMeta; // first stage, read only by rstN
  logic rstN; // synchronised active-low reset
  // async assert, two-flop release
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // increment decision for the current rounding mode
  function automatic logic rndInc(input logic [1:0] rm, input logic sgn,
                                  input logic lsb, input logic half, input logic st);
    case (rm)
      fpucw_pkg::RM_NEAR: rndInc = half & (st | lsb);
      fpucw_pkg::RM_PINF: rndInc = ~sgn & (half | st);
      fpucw_pkg::RM_MINF: rndInc = sgn & (half | st);
      default: rndInc = 1'b0;
    endcase
  endfunction
  // leading zero count over 64 bits; scanning upward lets the highest set bit win
  function automatic logic [6:0] clz64(input logic [63:0] v);
    clz64 = 7'h40;
    for (int i = 0; i < 64; i++) begin
      if (v[i])
        clz64 = 7'(63 - i);
    end
  endfunction
  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  logic [31:0] fp_control_status; // fp_control_status
  logic [4:0] fmt;
  logic [4:0] selField; // control-register selector / source_reg_field
  logic isFp, isMtc, isCvtD, isCvtL, badFmt;
  logic [1:0] rm;
  assign fmt = req.word[25:21];
  assign selField = req.word[15:11];
  assign rm = fp_control_status[fpucw_pkg::RM_LO +: 2];
  assign isFp = req.valid && req.word[31:26] == fpucw_pkg::OPC_FP;
  // sub-opcode, gpr_source_field in 20..16, low eleven bits zero
  assign isMtc = isFp && fmt == fpucw_pkg::SUB_MTC && req.word[10:0] == 11'h000;
  assign isCvtD = isFp && req.word[5:0] == fpucw_pkg::FN_CVTD && req.word[20:16] == 5'h00;
  assign isCvtL = isFp && req.word[5:0] == fpucw_pkg::FN_CVTL && req.word[20:16] == 5'h00;
  // formats outside the instruction's set are reserved
  assign badFmt = (isCvtD && !(fmt == fpucw_pkg::FMT_S || fmt == fpucw_pkg::FMT_W || fmt == fpucw_pkg::FMT_L)) ||
                  (isCvtL && !(fmt == fpucw_pkg::FMT_S || fmt == fpucw_pkg::FMT_D));
  // -------------------------------------------------------------
  // operand unpack to double fields
  // -------------------------------------------------------------
  logic dSign, dNan, dSnan, dInf, dDen, dZero;
  logic [10:0] dExp;
  logic [51:0] dFrac;
  // single widens exactly; subnormals go to software
  always_comb begin
    if (fmt == fpucw_pkg::FMT_S) begin
      dSign = req.operand[31];
      dFrac = {req.operand[22:0], 29'h0};
      dExp = (req.operand[30:23] == 8'hFF) ? fpucw_pkg::DBL_EXPMAX :
             (req.operand[30:23] == 8'h00) ? 11'h000 : {3'h0, req.operand[30:23]} + fpucw_pkg::SGL_REBIAS;
    end else begin
      dSign = req.operand[63];
      dExp = req.operand[62:52];
      dFrac = req.operand[51:0];
    end
    dNan = dExp == fpucw_pkg::DBL_EXPMAX && dFrac != 52'h0;
    dSnan = dNan && !dFrac[51];
    dInf = dExp == fpucw_pkg::DBL_EXPMAX && dFrac == 52'h0;
    dDen = dExp == 11'h000 && dFrac != 52'h0;
    dZero = dExp == 11'h000 && dFrac == 52'h0;
  end
  // -------------------------------------------------------------
  // integer to double
  // -------------------------------------------------------------
  logic [63:0] intIn, intMag, intNorm;
  logic [6:0] intLz;
  logic intInc, intInexact;
  logic [53:0] intSum;
  logic [10:0] intExp;
  logic [63:0] intDbl;
  // word inputs fit 53 bits, so guard and sticky stay clear
  always_comb begin
    intIn = (fmt == fpucw_pkg::FMT_W) ? {{32{req.operand[31]}}, req.operand[31:0]} : req.operand;
    intMag = intIn[63] ? 64'(-intIn) : intIn;
    intLz = clz64(intMag);
    intNorm = intMag << intLz;
    intInc = rndInc(rm, intIn[63], intNorm[11], intNorm[10], |intNorm[9:0]);
    intInexact = intNorm[10] | (|intNorm[9:0]);
    intSum = {1'b0, intNorm[63:11]} + {53'h0, intInc};
    intExp = fpucw_pkg::INT_EXPTOP - {4'h0, intLz} + {10'h0, intSum[53]};
    intDbl = (intMag == 64'h0) ? 64'h0 : {intIn[63], intExp, intSum[53] ? 52'h0 : intSum[51:0]};
  end
  // -------------------------------------------------------------
  // float to long
  // -------------------------------------------------------------
  logic signed [12:0] unbExp;
  logic [127:0] wide;
  logic [63:0] lInt;
  logic lHalf, lSticky, lInc, lOvf;
  logic [64:0] lMag;
  logic [63:0] lRes;
  // 64 fraction bits below the point make guard and sticky plain slices
  always_comb begin
    unbExp = 13'(signed'({2'b00, dExp})) - 13'(signed'({2'b00, fpucw_pkg::DBL_BIAS}));
    wide = 128'h0;
    lInt = 64'h0;
    lHalf = 1'b0;
    lSticky = 1'b0;
    lOvf = 1'b0;
    if (unbExp < -13'sd1) begin
      lSticky = !dZero; // zero also lands here and carries no sticky bit
    end else if (unbExp > 13'sd63) begin
      lOvf = 1'b1;
    end else if (unbExp == 13'sd63) begin
      lOvf = !(dSign && dFrac == 52'h0); // only -2^63 survives
      lInt = 64'h8000_0000_0000_0000;
    end else begin
      wide = {75'h0, 1'b1, dFrac} << 7'(unbExp + 13'sd12);
      lInt = wide[127:64];
      lHalf = wide[63];
      lSticky = |wide[62:0];
    end
    lInc = rndInc(rm, dSign, lInt[0], lHalf, lSticky);
    lMag = {1'b0, lInt} + {64'h0, lInc};
    // range judged on the rounded magnitude
    if (dSign ? lMag > fpucw_pkg::LONG_NEGMAG : lMag > {1'b0, fpucw_pkg::LONG_MAXPOS})
      lOvf = 1'b1;
    lRes = dSign ? 64'(-lMag) : lMag[63:0];
  end
  // -------------------------------------------------------------
  // result and cause selection for conversions
  // -------------------------------------------------------------
  logic [5:0] cvCause; // E V Z O U I
  logic [63:0] cvData;
  always_comb begin
    cvCause = 6'h00;
    cvData = 64'h0;
    if (isCvtD) begin
      if (fmt != fpucw_pkg::FMT_S) begin
        cvData = intDbl;
        cvCause[fpucw_pkg::BIT_I] = intInexact && fmt == fpucw_pkg::FMT_L;
      end else if (dDen) begin
        cvCause[5] = 1'b1;
      end else if (dNan) begin
        cvData = fpucw_pkg::DBL_QNAN;
        cvCause[fpucw_pkg::BIT_V] = dSnan;
      end else begin
        cvData = {dSign, dExp, dFrac};
      end
    end else begin
      if (dDen) begin
        cvCause[5] = 1'b1;
      end else if (dNan || dInf || lOvf) begin
        cvCause[fpucw_pkg::BIT_V] = 1'b1;
        cvData = fpucw_pkg::LONG_MAXPOS;
      end else begin
        cvData = lRes;
        cvCause[fpucw_pkg::BIT_I] = lHalf | lSticky;
      end
    end
  end
  // -------------------------------------------------------------
  // next control/status value
  // -------------------------------------------------------------
  logic [31:0] gw; // low general_register word
  logic [31:0] next_fp_control_status;
  logic mtcOk, mtcTrap, cvTrap, isCv;
  assign gw = req.general_register[31:0];
  assign isCv = (isCvtD || isCvtL) && cuEnable && !badFmt;
  assign cvTrap = cvCause[5] | (|(cvCause[4:0] & fp_control_status[fpucw_pkg::EN_LO +: 5]));
  // undefined selectors and nonzero guard bits leave the register alone
  always_comb begin
    next_fp_control_status = fp_control_status;
    mtcOk = 1'b0;
    if (isMtc && cuEnable) begin
      case (selField)
        fpucw_pkg::SEL_CONDV: begin
          mtcOk = gw[31:8] == 24'h0;
          if (mtcOk) begin
            next_fp_control_status[31:25] = gw[7:1];
            next_fp_control_status[fpucw_pkg::CC_BIT] = gw[0];
          end
        end
        fpucw_pkg::SEL_CAUSEV: begin
          mtcOk = gw[22:18] == 5'h00;
          if (mtcOk) begin
            next_fp_control_status[17:12] = gw[17:12];
            next_fp_control_status[6:2] = gw[6:2];
          end
        end
        fpucw_pkg::SEL_ENV: begin
          mtcOk = gw[22:18] == 5'h00;
          if (mtcOk) begin
            next_fp_control_status[fpucw_pkg::FS_BIT] = gw[2];
            next_fp_control_status[11:7] = gw[11:7];
            next_fp_control_status[1:0] = gw[1:0];
          end
        end
        fpucw_pkg::SEL_FULL: begin
          mtcOk = gw[22:18] == 5'h00;
          if (mtcOk)
            next_fp_control_status = gw;
        end
        default: mtcOk = 1'b0;
      endcase
    end else if (isCv) begin
      next_fp_control_status[17:12] = cvCause;
      if (!cvTrap)
        next_fp_control_status[6:2] = fp_control_status[6:2] | cvCause[4:0];
    end else if (regWrite && regAddr == fpucw_pkg::REG_CSR) begin
      next_fp_control_status = regWdata;
    end
  end
  // except on condition-view writes, unimplemented cause always traps; others need their enable
  assign mtcTrap = mtcOk && selField != fpucw_pkg::SEL_CONDV &&
                   (next_fp_control_status[fpucw_pkg::CAUSE_UNIMP] ||
                    |(next_fp_control_status[fpucw_pkg::CAUSE_LO +: 5] & next_fp_control_status[fpucw_pkg::EN_LO +: 5]));
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  fpucw_pkg::fpucw_trap_t trapStage; // raised with the register update
  fpucw_pkg::fpucw_exc_t lastExc; // last exception code, readable
  // control/status register
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN)
      fp_control_status <= fpucw_pkg::FP_CONTROL_STATUS_RST;
    else
      fp_control_status <= next_fp_control_status;
  end
  // conversion result; nothing written when trapping
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      res <= '0;
    end else begin
      res.valid <= isCv && !cvTrap;
      res.dest <= req.word[10:6];
      res.data <= cvData;
    end
  end
  // trap staged on the same edge as the register write
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      trapStage <= '0;
    end else begin
      trapStage <= '0;
      if (isFp && !cuEnable) begin
        trapStage.valid <= 1'b1;
        trapStage.code <= fpucw_pkg::EXC_CPU;
      end else if (badFmt) begin
        trapStage.valid <= 1'b1;
        trapStage.code <= fpucw_pkg::EXC_RI;
      end else if (mtcTrap || (isCv && cvTrap)) begin
        trapStage.valid <= 1'b1;
        trapStage.code <= fpucw_pkg::EXC_FPE;
      end
    end
  end
  // trap output follows the updated register by one cycle
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN)
      trap <= '0;
    else
      trap <= trapStage;
  end
  // last exception code for software
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN)
      lastExc <= fpucw_pkg::EXC_NONE;
    else if (trapStage.valid)
      lastExc <= trapStage.code;
  end
  // -------------------------------------------------------------
  // software read port
  // -------------------------------------------------------------
  // read data stands in the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= 32'h0000_0000;
    end else if (regRead) begin
      case (regAddr)
        fpucw_pkg::REG_CSR: regRdata <= fp_control_status;
        fpucw_pkg::REG_STAT: regRdata <= {30'h0, lastExc};
        default: regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end
endmodule // fpucw_core
`default_nettype wire

// ==== common/fpucw_pkg.sv ====
// constants, carriers and codes shared by the fp control-write and convert block
package fpucw_pkg;
  // -------------------------------------------------------------
  // instruction encoding
  // -------------------------------------------------------------
  localparam logic [5:0] OPC_FP = 6'h11; // fp_major_opcode
  localparam logic [4:0] SUB_MTC = 5'h06; // move_to_fp_control sub-opcode
  localparam logic [5:0] FN_CVTD = 6'h21; // convert_to_double function
  localparam logic [5:0] FN_CVTL = 6'h25; // convert_to_long function
  localparam logic [4:0] FMT_S = 5'h10;
  localparam logic [4:0] FMT_D = 5'h11;
  localparam logic [4:0] FMT_W = 5'h14;
  localparam logic [4:0] FMT_L = 5'h15;
  // control-register selectors (views of fp_control_status)
  localparam logic [4:0] SEL_CONDV = 5'h19;
  localparam logic [4:0] SEL_CAUSEV = 5'h1A;
  localparam logic [4:0] SEL_ENV = 5'h1C;
  localparam logic [4:0] SEL_FULL = 5'h1F;
  // -------------------------------------------------------------
  // fp_control_status fields
  // -------------------------------------------------------------
  localparam int RM_LO = 0;
  localparam int FLAG_LO = 2;
  localparam int EN_LO = 7;
  localparam int CAUSE_LO = 12;
  localparam int CAUSE_UNIMP = 17;
  localparam int CC_BIT = 23;
  localparam int FS_BIT = 24;
  localparam int BIT_V = 4; // offsets inside a five-bit field: V Z O U I
  localparam int BIT_I = 0;
  localparam logic [31:0] FP_CONTROL_STATUS_RST = 32'h0000_0000;
  localparam logic [1:0] RM_NEAR = 2'h0;
  localparam logic [1:0] RM_ZERO = 2'h1;
  localparam logic [1:0] RM_PINF = 2'h2;
  localparam logic [1:0] RM_MINF = 2'h3;
  // -------------------------------------------------------------
  // numeric constants
  // -------------------------------------------------------------
  localparam logic [63:0] LONG_MAXPOS = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam logic [64:0] LONG_NEGMAG = 65'h0_8000_0000_0000_0000;
  localparam logic [63:0] DBL_QNAN = 64'h7FF8_0000_0000_0000;
  localparam logic [10:0] DBL_EXPMAX = 11'h7FF;
  localparam logic [10:0] DBL_BIAS = 11'h3FF;
  localparam logic [10:0] SGL_REBIAS = 11'h380;
  localparam logic [10:0] INT_EXPTOP = 11'h43E;
  // -------------------------------------------------------------
  // software register port
  // -------------------------------------------------------------
  localparam logic [3:0] REG_CSR = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    EXC_NONE = 2'b00,
    EXC_CPU = 2'b01,
    EXC_RI = 2'b10,
    EXC_FPE = 2'b11
  } fpucw_exc_t;
  typedef struct packed {
    logic valid;
    logic [31:0] word;
    logic [63:0] general_register;
    logic [63:0] operand;
  } fpucw_req_t;
  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic [63:0] data;
  } fpucw_res_t;
  typedef struct packed {
    logic valid;
    fpucw_exc_t code;
  } fpucw_trap_t;
endpackage

// ==== tb/fpucw_issuer.sv ====
// model of the issuing core that hands decoded instructions to the fp block
`timescale 1ns/10ps
`default_nettype none
module fpucw_issuer #(
  parameter bit FULL_REGS = 1'b1 // 32 fp registers, so long forms are legal
) (
  input wire logic sys_clk,
  output var fpucw_pkg::fpucw_req_t req
);
  // -------------------------------------------------------------
  // issue path
  // -------------------------------------------------------------
  initial req = '0;
  // one instruction per call, valid for exactly one cycle
  task automatic issue(input logic [31:0] w, input logic [63:0] g, input logic [63:0] op);
    logic skip;
    skip = 1'b0;
    // only the four defined control views are ever selected
    if (w[25:21] == fpucw_pkg::SUB_MTC && w[5:0] == 6'h00 && !(w[15:11] inside {5'h19, 5'h1A, 5'h1C, 5'h1F})) begin
      skip = 1'b1;
    end
    // long forms stay unused in 16-register mode
    if (!FULL_REGS && (w[5:0] == fpucw_pkg::FN_CVTL || w[25:21] == fpucw_pkg::FMT_L)) begin
      skip = 1'b1;
    end
    @(posedge sys_clk);
    if (!skip) begin
      req <= '{1'b1, w, g, op};
    end
    @(posedge sys_clk);
    // released lines show no stale copy of the last instruction
    req <= '{1'b0, ~w, ~g, ~op};
  endtask
endmodule // fpucw_issuer
`default_nettype wire

// ==== tb/fpucw_core_props.sv ====
// concurrent checks on the ports of the fp control-write and convert block
`timescale 1ns/10ps
`default_nettype none
module fpucw_core_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire fpucw_pkg::fpucw_req_t req,
  input wire logic cuEnable,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire fpucw_pkg::fpucw_res_t res,
  input wire fpucw_pkg::fpucw_trap_t trap
);
  // -------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------
  logic fpOp; // fp opcode on the port
  logic cvtD; // usable convert to double
  logic cvtL; // usable convert to long
  logic mvOp; // usable control write
  logic [4:0] fmt; // format or sub-opcode field
  assign fmt = req.word[25:21];
  assign fpOp = req.valid && req.word[31:26] == fpucw_pkg::OPC_FP;
  assign cvtD = fpOp && cuEnable && req.word[5:0] == fpucw_pkg::FN_CVTD && req.word[20:16] == 5'h00;
  assign cvtL = fpOp && cuEnable && req.word[5:0] == fpucw_pkg::FN_CVTL && req.word[20:16] == 5'h00;
  assign mvOp = fpOp && cuEnable && fmt == fpucw_pkg::SUB_MTC && req.word[10:0] == 11'h000;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // -------------------------------------------------------------
  // sequences
  // -------------------------------------------------------------
  sequence s_full_move;
    mvOp && req.word[15:11] == fpucw_pkg::SEL_FULL && req.general_register[22:18] == 5'h00;
  endsequence
  sequence s_csr_read;
    regRead && regAddr == fpucw_pkg::REG_CSR;
  endsequence
  sequence s_long_inf;
    cvtL && fmt == fpucw_pkg::FMT_D && req.operand[62:52] == fpucw_pkg::DBL_EXPMAX;
  endsequence
  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  a_unusable_trap: assert property (fpOp && !cuEnable |-> ##1 !res.valid ##1 trap.valid && trap.code == fpucw_pkg::EXC_CPU)
    else $error("unusable coprocessor did not trap");
  a_word_exact: assert property (cvtD && fmt == fpucw_pkg::FMT_W |-> ##1 res.valid && res.dest == $past(req.word[10:6]) ##1 !trap.valid)
    else $error("word to double not exact or misplaced");
  a_bad_format: assert property ((cvtD && !(fmt inside {5'h10, 5'h14, 5'h15}) || cvtL && !(fmt inside {5'h10, 5'h11}))
    && fmt != fpucw_pkg::SUB_MTC |-> ##1 !res.valid ##1 trap.valid && trap.code == fpucw_pkg::EXC_RI)
    else $error("bad format not reserved");
  a_trap_follows: assert property (trap.valid |-> $past(req.valid, 2))
    else $error("trap without an instruction two cycles before");
  a_move_quiet: assert property (mvOp |=> !res.valid)
    else $error("control write produced a result");
  a_full_readback: assert property (s_full_move ##1 s_csr_read |=> regRdata == $past(req.general_register[31:0], 2))
    else $error("full write not visible next cycle");
  a_long_default: assert property (s_long_inf ##1 res.valid |-> res.data == fpucw_pkg::LONG_MAXPOS)
    else $error("invalid long result not the default");
  a_trap_nores: assert property (trap.valid |-> !$past(res.valid))
    else $error("trapping instruction also wrote a result");
endmodule // fpucw_core_props
bind fpucw_core fpucw_core_props u_props (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .cuEnable(cuEnable),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .res(res), .trap(trap));
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the fp control-write and convert block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic sysClk = 1'b0; // 100 ns period
  logic rstB = 1'b0; // active low
  logic cuEnable = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata;
  fpucw_pkg::fpucw_req_t req;
  fpucw_pkg::fpucw_res_t res;
  fpucw_pkg::fpucw_trap_t trap;
  int numErrors = 0;
  int numChecks = 0;
  logic gotRes, gotTrap; // what the last instruction produced
  logic [1:0] gotCode;
  logic [4:0] gotDest;
  logic [63:0] gotData;
  always #50 sysClk = ~sysClk;
  fpucw_issuer core (.sys_clk(sysClk), .req(req));
  fpucw_core dut (.sys_clk(sysClk), .rst_b(rstB), .req(req), .cuEnable(cuEnable), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .res(res), .trap(trap));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    numChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic completeRun();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sysClk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sysClk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sysClk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sysClk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
  // result one cycle after the taking edge, trap one more later
  task automatic exec(input logic [31:0] w, input logic [63:0] g, input logic [63:0] op);
    core.issue(w, g, op);
    #1;
    gotRes = res.valid;
    gotData = res.data;
    gotDest = res.dest;
    @(posedge sysClk);
    #1;
    gotTrap = trap.valid;
    gotCode = trap.code;
  endtask
  function automatic logic [31:0] mv(input logic [4:0] s);
    return {fpucw_pkg::OPC_FP, fpucw_pkg::SUB_MTC, 5'h03, s, 11'h000};
  endfunction
  function automatic logic [31:0] cv(input logic [5:0] fn, input logic [4:0] f);
    return {fpucw_pkg::OPC_FP, f, 5'h00, 5'h02, 5'h13, fn};
  endfunction
  // expected register after a write through one view
  function automatic logic [31:0] merge(input logic [4:0] s, input logic [31:0] o, input logic [31:0] v);
    case (s)
      5'h19: return {v[7:1], o[24], v[0], o[22:0]};
      5'h1A: return {o[31:18], v[17:12], o[11:7], v[6:2], o[1:0]};
      5'h1C: return {o[31:25], v[2], o[23:12], v[11:7], o[6:2], v[1:0]};
      default: return v;
    endcase
  endfunction
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic testViews();
    logic [4:0] sel [9];
    logic [31:0] val [9];
    logic [8:0] trp;
    logic [31:0] v, e;
    sel = '{5'h1F, 5'h19, 5'h1A, 5'h1C, 5'h1C, 5'h1A, 5'h1C, 5'h1A, 5'h1F};
    val = '{32'hAA01_0001, 32'h0000_00A5, 32'hFF80_F07C, 32'h0000_0F87, 32'h0, 32'h0, 32'h0000_0880,
      32'h0000_1000, 32'h0};
    trp = 9'b0_1000_1000;
    e = 32'h0;
    for (int i = 0; i < 9; i++) begin
      exec(mv(sel[i]), {32'hDEAD_BEEF, val[i]}, 64'h0);
      check({gotRes, gotTrap}, {1'b0, trp[i]});
      rd(fpucw_pkg::REG_CSR, v);
      e = merge(sel[i], e, val[i]);
      check(v, e);
    end
  endtask
  task automatic testFullTraps();
    logic [31:0] v, w;
    for (int i = 0; i < 6; i++) begin
      w = (32'h1 << (12 + i)) | ((i < 5) ? (32'h1 << (7 + i)) : 32'h0);
      exec(mv(5'h1F), {32'h0, w}, 64'h0);
      check({gotTrap, gotCode}, {1'b1, fpucw_pkg::EXC_FPE});
      rd(fpucw_pkg::REG_CSR, v);
      check(v, w);
      exec(mv(5'h1F), 64'h0, 64'h0);
    end
    // nonzero low field is not a control write
    exec(mv(5'h1F) | 32'h1, 64'h3, 64'h0);
    rd(fpucw_pkg::REG_CSR, v);
    check({gotTrap, v}, 33'h0);
  endtask
  task automatic testBackToBack();
    logic [31:0] v;
    fork
      exec(mv(5'h1F), {32'h1234_5678, 32'h5A03_F0E3}, 64'h0);
      begin
        repeat (2) @(posedge sysClk);
        regRead <= 1'b1;
        regAddr <= fpucw_pkg::REG_CSR;
        @(posedge sysClk);
        regRead <= 1'b0;
        #1;
        v = regRdata;
      end
    join
    check({v, gotTrap}, {32'h5A03_F0E3, 1'b1});
    exec(mv(5'h1F), 64'h0, 64'h0);
  endtask
  task automatic runCvt(input logic [5:0] fn, input logic [4:0] f, input logic [1:0] rm, input logic [63:0] op,
    input logic [63:0] d, input logic [5:0] cause);
    logic [31:0] v;
    wr(fpucw_pkg::REG_CSR, {30'h0, rm});
    exec(cv(fn, f), 64'h0, op);
    check({gotRes, gotDest, gotData}, {1'b1, 5'h13, d});
    rd(fpucw_pkg::REG_CSR, v);
    check(v[17:12], cause);
  endtask
  task automatic testConvert();
    for (int m = 0; m < 4; m++) begin
      runCvt(6'h25, 5'h11, m[1:0], 64'h4004_0000_0000_0000, (m == 2) ? 64'h3 : 64'h2, 6'h01);
      runCvt(6'h25, 5'h11, m[1:0], 64'hC004_0000_0000_0000, 64'h0 - ((m == 3) ? 64'h3 : 64'h2), 6'h01);
    end
    runCvt(6'h25, 5'h11, 2'h0, 64'hC3E0_0000_0000_0000, 64'h8000_0000_0000_0000, 6'h00);
    runCvt(6'h25, 5'h11, 2'h0, 64'h43E0_0000_0000_0000, fpucw_pkg::LONG_MAXPOS, 6'h10);
    runCvt(6'h25, 5'h11, 2'h0, 64'h7FF0_0000_0000_0000, fpucw_pkg::LONG_MAXPOS, 6'h10);
    runCvt(6'h25, 5'h10, 2'h0, 64'h3F80_0000, 64'h1, 6'h00);
    runCvt(6'h21, 5'h10, 2'h0, 64'h3F80_0000, 64'h3FF0_0000_0000_0000, 6'h00);
    runCvt(6'h21, 5'h10, 2'h0, 64'h7F80_0001, fpucw_pkg::DBL_QNAN, 6'h10);
    runCvt(6'h21, 5'h14, 2'h3, 64'hFFFF_FFFF, 64'hBFF0_0000_0000_0000, 6'h00);
    runCvt(6'h21, 5'h15, 2'h0, 64'h0020_0000_0000_0001, 64'h4340_0000_0000_0000, 6'h01);
    runCvt(6'h21, 5'h15, 2'h2, 64'h0020_0000_0000_0001, 64'h4340_0000_0000_0001, 6'h01);
  endtask
  task automatic testRefusals();
    logic [31:0] v;
    // invalid enabled: no result, trap one cycle after the result slot
    wr(fpucw_pkg::REG_CSR, 32'h0000_0800);
    exec(cv(6'h25, 5'h11), 64'h0, 64'hFFF0_0000_0000_0000);
    check({gotRes, gotTrap, gotCode}, {2'b01, fpucw_pkg::EXC_FPE});
    rd(fpucw_pkg::REG_CSR, v);
    check(v[16], 1'b1);
    // subnormal single is left to software
    exec(cv(6'h21, 5'h10), 64'h0, 64'h1);
    check({gotRes, gotTrap, gotCode}, {2'b01, fpucw_pkg::EXC_FPE});
    exec(cv(6'h25, 5'h14), 64'h0, 64'h0);
    check({gotRes, gotTrap, gotCode}, {2'b01, fpucw_pkg::EXC_RI});
    exec(cv(6'h21, 5'h11), 64'h0, 64'h0);
    check({gotRes, gotTrap, gotCode}, {2'b01, fpucw_pkg::EXC_RI});
    @(posedge sysClk);
    cuEnable <= 1'b0;
    exec(cv(6'h21, 5'h10), 64'h0, 64'h3F80_0000);
    check({gotRes, gotTrap, gotCode}, {2'b01, fpucw_pkg::EXC_CPU});
    cuEnable <= 1'b1;
    rd(fpucw_pkg::REG_STAT, v);
    check(v[1:0], fpucw_pkg::EXC_CPU);
    rd(4'h8, v);
    check(v, 32'h0);
  endtask
  // -------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sysClk);
    rstB <= 1'b1;
    repeat (3) @(posedge sysClk);
    testViews();
    testFullTraps();
    testBackToBack();
    testConvert();
    testRefusals();
    completeRun();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (6000) @(posedge sysClk);
    numErrors++;
    completeRun();
  end
endmodule // testbench
`default_nettype wire
